// >>> core/pcs_config_loader.sv
// configuration store, serial-mode entry/exit and copy into working registers
// assumes ser_* and the flag inputs come from mclk logic; pins arrive raw
`include "pcs_defs.svh"
`default_nettype none
module pcs_config_loader #(
    parameter int unsigned ENTRY_MIN_CYCLES = `PCS_ENTRY_MIN_CYC,
    parameter int unsigned ENTRY_MAX_CYCLES = `PCS_ENTRY_MAX_CYC,
    parameter int unsigned NV_WRITE_CYCLES = `PCS_NV_WRITE_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic enable_pin,
    input wire logic [2:0] high_side_inputs,
    input wire logic [2:0] low_side_inputs,
    input wire logic fault_line_in,
    output logic fault_line_out,
    output logic fault_line_oe,
    input wire logic errors_pending,
    input wire logic regulator_overvolt_flag,
    input wire logic drain_fault_flag,
    input wire logic [2:0] ser_addr,
    input wire logic [7:0] ser_wdata,
    input wire logic ser_wr,
    input wire logic ser_rd,
    output logic [7:0] ser_rdata,
    output logic ser_rvalid,
    output logic ser_busy,
    output logic serial_mode,
    output logic predriver_blocked,
    output logic bridge_tristate,
    output logic [2:0] phase_gap_time,
    output logic [2:0] drain_monitor_threshold,
    output logic [1:0] drain_monitor_blank,
    output logic [2:0] sense_gain_sel,
    output logic boost_reference_sel,
    output logic fault_pwm_rate_sel,
    output logic regulator_overvolt_cutoff_en,
    output logic drain_fault_cutoff_en,
    output logic drain_comparator_en,
    output logic gate_uv_comparator_en,
    output logic boost_pump_en,
    output logic serial_port_allow,
    output logic ecc_corrected,
    output logic ecc_uncorrectable
);
    import pcs_pkg::*;

    // ------------------------------------------------------------
    // constants
    // ------------------------------------------------------------
    localparam logic [15:0] MIN_C = 16'(ENTRY_MIN_CYCLES);
    localparam logic [15:0] MAX_C = 16'(ENTRY_MAX_CYCLES);
    localparam logic [7:0] WLAST = 8'(NV_WRITE_CYCLES - 1);
    localparam logic [5:0][12:0] NV_INIT = {
        pcs_encode(`PCS_DEF_IFC), pcs_encode(`PCS_DEF_PROT),
        pcs_encode(`PCS_DEF_MON), pcs_encode(`PCS_DEF_DRV),
        pcs_encode(`PCS_DEF_RSV), pcs_encode(`PCS_DEF_RSV)};
    localparam logic [3:0][7:0] CFG_INIT = {
        `PCS_DEF_IFC, `PCS_DEF_PROT, `PCS_DEF_MON, `PCS_DEF_DRV};

    // bits the host may change in each word; reserved words take none
    function automatic logic [7:0] wmask(input logic [2:0] a);
        case (a)
            `PCS_W_DRV: wmask = `PCS_WM_DRV;
            `PCS_W_MON: wmask = `PCS_WM_MON;
            `PCS_W_PROT: wmask = `PCS_WM_PROT;
            `PCS_W_IFC: wmask = `PCS_WM_IFC;
            default: wmask = 8'h00;
        endcase
    endfunction : wmask

    // ------------------------------------------------------------
    // pins and decoder
    // ------------------------------------------------------------
    logic [7:0] pins_s;
    logic en_s;
    logic [2:0] hs_s;
    logic [2:0] ls_s;
    logic flt_s;
    logic [2:0] dec_addr;
    logic [7:0] dec_data;
    logic dec_single;
    logic dec_double;
    pcs_core_t r;
    pcs_core_t n;

    pcs_sync #(
        .W(8)
    ) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .d_in({enable_pin, high_side_inputs, low_side_inputs, fault_line_in}),
        .q(pins_s)
    );

    assign {en_s, hs_s, ls_s, flt_s} = pins_s;

    // one decoder: copy owns it in ST_COPY, the serial port otherwise
    assign dec_addr = (r.st == ST_COPY) ? r.idx : ser_addr;

    pcs_secded u_dec (
        .code(r.nv[dec_addr]),
        .data(dec_data),
        .single_err(dec_single),
        .double_err(dec_double)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic entry_ok;
    logic allow;
    logic [7:0] merged;
    logic [2:0] rel;

    always_comb begin
        n = r;
        n.rvalid = 1'b0;
        allow = r.cfg[3][`PCS_ALLOW_B];
        entry_ok = !en_s && !errors_pending && (&hs_s) && !(|ls_s);
        rel = r.idx - 3'd2;
        merged = (dec_data & ~wmask(ser_addr)) | (ser_wdata & wmask(ser_addr));
        if (ser_addr == `PCS_W_IFC) begin
            merged[`PCS_ALLOW_B] = dec_data[`PCS_ALLOW_B] & ser_wdata[`PCS_ALLOW_B];
        end

        // write engine runs in any state so exit can wait on it
        if (r.wbusy) begin
            n.wcnt = r.wcnt + 8'd1;
            if (r.wcnt == WLAST) begin
                n.nv[r.waddr] = r.wcode;
                n.wbusy = 1'b0;
            end
        end

        case (r.st)
            ST_COPY: begin
                n.blocked = 1'b1;
                if (r.idx == `PCS_W_RSV0) begin
                    n.ecc_fix = dec_single;
                    n.ecc_bad = dec_double;
                end else begin
                    n.ecc_fix = r.ecc_fix | dec_single;
                    n.ecc_bad = r.ecc_bad | dec_double;
                end
                if (r.idx >= `PCS_W_DRV) begin
                    n.cfg[rel[1:0]] = dec_data;
                end
                if (r.idx == `PCS_W_IFC) begin
                    n.st = ST_NORMAL;
                    n.blocked = 1'b0;
                    n.fault_oe = 1'b0;
                end else begin
                    n.idx = r.idx + 3'd1;
                end
            end
            ST_NORMAL: begin
                // low pulse measured only while the pins stay parked
                if (!entry_ok) begin
                    n.low_cnt = 16'h0;
                end else if (!flt_s) begin
                    if (r.low_cnt != 16'hffff) begin
                        n.low_cnt = r.low_cnt + 16'h1;
                    end
                end else begin
                    if (r.low_cnt >= MIN_C && r.low_cnt <= MAX_C) begin
                        n.st = ST_SERIAL;
                        n.blocked = 1'b1;
                    end
                    n.low_cnt = 16'h0;
                end
            end
            ST_SERIAL: begin
                if (en_s) begin
                    n.st = ST_EXIT;
                    n.fault_oe = 1'b1;
                end else if (allow && !r.wbusy) begin
                    if (ser_wr) begin
                        if (wmask(ser_addr) != 8'h00) begin
                            n.wbusy = 1'b1;
                            n.wcnt = 8'h0;
                            n.waddr = ser_addr;
                            n.wcode = pcs_encode(merged);
                        end
                    end else if (ser_rd) begin
                        n.rdata = dec_data;
                        n.rvalid = 1'b1;
                    end
                end
            end
            ST_EXIT: begin
                n.fault_oe = 1'b1;
                if (!r.wbusy) begin
                    n.st = ST_COPY;
                    n.idx = `PCS_W_RSV0;
                end
            end
            default: begin
                n.st = ST_COPY;
                n.idx = `PCS_W_RSV0;
            end
        endcase

        // mode flag registered so the output comes straight from a flop
        n.ser_mode = (n.st == ST_SERIAL);

        // bridge cut: blocked, enable low or an enabled protection flag
        n.bridge_off = n.blocked || !en_s
            || (r.cfg[2][`PCS_ROV_B] && regulator_overvolt_flag)
            || (r.cfg[2][`PCS_DF_B] && drain_fault_flag);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // reset lands in the copy so the working set is loaded like after exit
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
            r.st <= ST_COPY;
            r.nv <= NV_INIT;
            r.cfg <= CFG_INIT;
            r.blocked <= 1'b1;
            r.bridge_off <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from r except fault_line_out, which is tied low
    // ------------------------------------------------------------
    assign fault_line_out = 1'b0; // open drain: only ever pulls low
    assign fault_line_oe = r.fault_oe;
    assign ser_rdata = r.rdata;
    assign ser_rvalid = r.rvalid;
    assign ser_busy = r.wbusy;
    assign serial_mode = r.ser_mode;
    assign predriver_blocked = r.blocked;
    assign bridge_tristate = r.bridge_off;
    assign phase_gap_time = r.cfg[0][`PCS_GAP_F];
    assign drain_monitor_threshold = r.cfg[0][`PCS_THR_F];
    assign boost_reference_sel = r.cfg[0][`PCS_BREF_B];
    assign drain_monitor_blank = r.cfg[1][`PCS_BLANK_F];
    assign fault_pwm_rate_sel = r.cfg[1][`PCS_PWM_B];
    assign sense_gain_sel = r.cfg[1][`PCS_GAIN_F];
    assign regulator_overvolt_cutoff_en = r.cfg[2][`PCS_ROV_B];
    assign drain_fault_cutoff_en = r.cfg[2][`PCS_DF_B];
    assign drain_comparator_en = r.cfg[2][`PCS_CMP_B];
    assign gate_uv_comparator_en = r.cfg[2][`PCS_VGS_B];
    assign boost_pump_en = r.cfg[2][`PCS_PUMP_B];
    assign serial_port_allow = r.cfg[3][`PCS_ALLOW_B];
    assign ecc_corrected = r.ecc_fix;
    assign ecc_uncorrectable = r.ecc_bad;
endmodule : pcs_config_loader
`default_nettype wire

// >>> core/pcs_defs.svh
// constants of the predriver configuration store: offsets, fields, defaults, timing
// assumes a 100 MHz mclk; included by pcs_config_loader by bare name
//
// Function
// - stored words carry a code correcting one flipped bit, flagging two
// - 3-bit phase gap time field, default code 011
// - 3-bit drain monitor threshold field, default code 111
// - 2-bit drain monitor blanking field, default code 10
// - 3-bit sense gain select field, default code 011
// - boost reference select, 0 ground, 1 motor supply, default 0
// - serial access needs allow bit, default 1, writes may only clear it
// - regulator overvolt flag tri-states bridge when its cutoff enable is set
// - drain fault flag tri-states bridge when its cutoff enable is set
// - drain comparator runs only while its enable bit is 1, default 1
// - fault line pwm rate select, 1 fast, 0 slow, default 1
// - boost charge pump runs only while its enable is 1, default 0
// - serial entry needs enable low, errors cleared, parked inputs, timed low pulse
// - in serial mode the host reads the stored words and programs all but the reserved ones
// - enable high ends serial mode: finish write, copy store, then normal
// - fault line held low from exit request until the copy completes
// - driver blocked after reset and serial exit until the copy completes
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH

// ------------------------------------------------------------
// word offsets
// ------------------------------------------------------------
`define PCS_W_RSV0 3'h0
`define PCS_W_RSV1 3'h1
`define PCS_W_DRV 3'h2
`define PCS_W_MON 3'h3
`define PCS_W_PROT 3'h4
`define PCS_W_IFC 3'h5

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define PCS_GAP_F 7:5
`define PCS_THR_F 4:2
`define PCS_BREF_B 1
`define PCS_BLANK_F 7:6
`define PCS_PWM_B 5
`define PCS_GAIN_F 3:1
`define PCS_ROV_B 7
`define PCS_DF_B 6
`define PCS_CMP_B 5
`define PCS_VGS_B 4
`define PCS_PUMP_B 2
`define PCS_ALLOW_B 7

// ------------------------------------------------------------
// reset contents and host-writable bits
// ------------------------------------------------------------
`define PCS_DEF_RSV 8'h00
`define PCS_DEF_DRV 8'h7c
`define PCS_DEF_MON 8'ha6
`define PCS_DEF_PROT 8'he0
`define PCS_DEF_IFC 8'hc0
`define PCS_WM_DRV 8'hfe
`define PCS_WM_MON 8'hee
`define PCS_WM_PROT 8'hf4
`define PCS_WM_IFC 8'h80

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define PCS_CLK_NS 10
`define PCS_ENTRY_MIN_NS 256000
`define PCS_ENTRY_MAX_NS 512000
`define PCS_ENTRY_MIN_CYC ((`PCS_ENTRY_MIN_NS + `PCS_CLK_NS - 1) / `PCS_CLK_NS)
`define PCS_ENTRY_MAX_CYC (`PCS_ENTRY_MAX_NS / `PCS_CLK_NS)
`define PCS_NV_WRITE_CYC 16

`endif

// >>> core/pcs_pkg.sv
// types and the check-bit encoder of the configuration store
// assumes nothing of its surroundings
`default_nettype none
package pcs_pkg;

    // loader states
    typedef enum logic [1:0] {
        ST_COPY,
        ST_NORMAL,
        ST_SERIAL,
        ST_EXIT
    } pcs_state_t;

    // all state of the loader
    typedef struct packed {
        pcs_state_t st;
        logic [15:0] low_cnt;
        logic [5:0][12:0] nv;
        logic wbusy;
        logic [7:0] wcnt;
        logic [2:0] waddr;
        logic [12:0] wcode;
        logic [2:0] idx;
        logic [3:0][7:0] cfg;
        logic blocked;
        logic fault_oe;
        logic bridge_off;
        logic ser_mode;
        logic [7:0] rdata;
        logic rvalid;
        logic ecc_fix;
        logic ecc_bad;
    } pcs_core_t;

    // layout {overall, p8, p4, p2, p1, data}
    function automatic logic [12:0] pcs_encode(input logic [7:0] d);
        logic [3:0] p;
        p[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
        p[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
        p[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
        p[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
        return {^{d, p}, p, d};
    endfunction : pcs_encode

endpackage : pcs_pkg
`default_nettype wire

// >>> core/pcs_secded.sv
// check-bit decoder: corrects one flipped bit, flags two
// assumes the code layout of pcs_pkg::pcs_encode; purely combinational
`default_nettype none
module pcs_secded (
    input wire logic [12:0] code,
    output logic [7:0] data,
    output logic single_err,
    output logic double_err
);
    import pcs_pkg::*;

    // hamming position of each data bit
    localparam logic [3:0] POS [8] = '{4'd3, 4'd5, 4'd6, 4'd7, 4'd9, 4'd10, 4'd11, 4'd12};

    logic [3:0] syn;
    logic odd;
    logic [12:0] chk;

    // syndrome names the flipped position, overall parity tells one from two
    always_comb begin
        chk = pcs_encode(code[7:0]);
        syn = chk[11:8] ^ code[11:8];
        odd = ^code;
        data = code[7:0];
        single_err = odd;
        double_err = !odd && (syn != 4'h0);
        for (int i = 0; i < 8; i++) begin
            if (odd && syn == POS[i]) begin
                data[i] = ~code[i];
            end
        end
    end
endmodule : pcs_secded
`default_nettype wire

// >>> core/pcs_sync.sv
// two-flop synchroniser for pin inputs
// assumes inputs asynchronous to mclk
`default_nettype none
module pcs_sync #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } pcs_sync_t;

    pcs_sync_t r;
    pcs_sync_t n;

    // first stage feeds only the second
    always_comb begin
        n.s1 = d_in;
        n.s2 = r.s1;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign q = r.s2;
endmodule : pcs_sync
`default_nettype wire

// >>> test/pcs_chk_properties.sv
// port checker of the configuration loader
// assumes binding onto pcs_config_loader with a 4-cycle store write
`default_nettype none
module pcs_chk #(
    parameter int unsigned NV_WRITE_CYCLES = 4
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic serial_mode,
    input wire logic predriver_blocked,
    input wire logic bridge_tristate,
    input wire logic fault_line_oe,
    input wire logic ser_rvalid,
    input wire logic ser_rd,
    input wire logic ser_wr,
    input wire logic [2:0] ser_addr,
    input wire logic ser_busy,
    input wire logic serial_port_allow,
    input wire logic regulator_overvolt_flag,
    input wire logic regulator_overvolt_cutoff_en,
    input wire logic drain_fault_flag,
    input wire logic drain_fault_cutoff_en
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    // copy after reset must release the driver within a few cycles
    blk_after_reset_a: assert property ($rose(rst_n) |-> predriver_blocked ##[4:8] !predriver_blocked)
        else $error("driver not released after reset copy");
    serial_blocks_a: assert property (serial_mode |-> predriver_blocked && bridge_tristate)
        else $error("driver free in serial mode");
    exit_line_a: assert property ($fell(serial_mode) |-> fault_line_oe && predriver_blocked)
        else $error("fault line not held at exit");
    release_line_a: assert property ($fell(fault_line_oe) |-> !predriver_blocked && $past(predriver_blocked))
        else $error("fault line and driver release apart");
    read_answer_a: assert property (ser_rvalid |-> $past(serial_mode) && $past(ser_rd) && $past(serial_port_allow))
        else $error("read answer without request");
    // write start only counts while the mode persists, an exit may race it
    write_start_a: assert property (serial_mode && serial_port_allow && !ser_busy && ser_wr
        && ser_addr inside {[3'h2:3'h5]} |=> ser_busy || !serial_mode)
        else $error("store write not started");
    write_len_a: assert property ($rose(ser_busy) |-> ser_busy[*4] ##1 !ser_busy)
        else $error("store write length wrong");
    allow_no_set_a: assert property (!serial_port_allow |=> !serial_port_allow)
        else $error("serial allow set again");
    fault_cutoff_a: assert property (regulator_overvolt_flag && regulator_overvolt_cutoff_en
        || drain_fault_flag && drain_fault_cutoff_en |=> bridge_tristate)
        else $error("bridge not cut off on fault");

    // main scenarios reached
    cover property ($rose(serial_mode));
    cover property (ser_rvalid);
    cover property ($fell(fault_line_oe));
endmodule : pcs_chk

bind pcs_config_loader pcs_chk #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_chk (
    .mclk, .rst_n, .serial_mode, .predriver_blocked, .bridge_tristate, .fault_line_oe, .ser_rvalid,
    .ser_rd, .ser_wr, .ser_addr, .ser_busy, .serial_port_allow, .regulator_overvolt_flag,
    .regulator_overvolt_cutoff_en, .drain_fault_flag, .drain_fault_cutoff_en
);
`default_nettype wire

// >>> test/pcs_host.sv
// host microcontroller model on the shared enable, bridge and fault pins
// assumes tb_top gives the fault line its pull-up; drives at the falling edge
`default_nettype none
module pcs_host (
    input wire logic mclk,
    output logic enable_pin,
    output logic [2:0] high_side_inputs,
    output logic [2:0] low_side_inputs,
    output logic fault_pull
);
    timeunit 1ns;
    timeprecision 100ps;

    // motor running inputs idle, fault line released
    initial begin
        enable_pin = 1'b1;
        high_side_inputs = 3'h0;
        low_side_inputs = 3'h0;
        fault_pull = 1'b0;
    end

    // motor to standstill before any serial traffic
    task automatic park();
        @(negedge mclk);
        enable_pin <= 1'b0;
        high_side_inputs <= 3'h7;
        low_side_inputs <= 3'h0;
    endtask : park

    // low pulse of n clocks, line released to the pull-up afterwards
    task automatic pulse(input int n);
        @(negedge mclk);
        fault_pull <= 1'b1;
        repeat (n) @(negedge mclk);
        fault_pull <= 1'b0;
    endtask : pulse

    // exit request; bridge inputs stay parked until the copy is done
    task automatic leave();
        @(negedge mclk);
        enable_pin <= 1'b1;
    endtask : leave
endmodule : pcs_host
`default_nettype wire

// >>> test/tb_top.sv
// self-checking bench of the configuration loader with a host pin model
// assumes entry limits cut to 20..40 clocks and a 4-cycle store write
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic mclk, rst_n, errors_pending, regulator_overvolt_flag, drain_fault_flag, ser_wr, ser_rd;
    logic enable_pin, fault_pull, fault_line_oe, ser_rvalid, ser_busy, serial_mode, predriver_blocked;
    logic bridge_tristate, boost_reference_sel, fault_pwm_rate_sel, regulator_overvolt_cutoff_en;
    logic drain_fault_cutoff_en, drain_comparator_en, gate_uv_comparator_en, boost_pump_en;
    logic serial_port_allow, ecc_corrected, ecc_uncorrectable;
    logic [2:0] ser_addr, high_side_inputs, low_side_inputs, phase_gap_time, drain_monitor_threshold;
    logic [2:0] sense_gain_sel;
    logic [1:0] drain_monitor_blank;
    logic [7:0] ser_wdata, ser_rdata;
    wire fault_wire;
    wire [7:0] w2, w3, w4, w5;
    int n_errors = 0;
    int n_tests = 0;

    // open-drain fault line with pull-up
    assign fault_wire = !(fault_line_oe || fault_pull);
    // working registers folded back into the stored word layout
    assign w2 = {phase_gap_time, drain_monitor_threshold, boost_reference_sel, 1'b0};
    assign w3 = {drain_monitor_blank, fault_pwm_rate_sel, 1'b0, sense_gain_sel, 1'b0};
    assign w4 = {regulator_overvolt_cutoff_en, drain_fault_cutoff_en, drain_comparator_en,
        gate_uv_comparator_en, 1'b0, boost_pump_en, 2'h0};
    assign w5 = {serial_port_allow, 7'h40};

    pcs_config_loader #(.ENTRY_MIN_CYCLES(20), .ENTRY_MAX_CYCLES(40), .NV_WRITE_CYCLES(4)) DUT (
        .mclk, .rst_n, .enable_pin, .high_side_inputs, .low_side_inputs, .fault_line_in(fault_wire),
        .fault_line_out(), .fault_line_oe, .errors_pending, .regulator_overvolt_flag, .drain_fault_flag,
        .ser_addr, .ser_wdata, .ser_wr, .ser_rd, .ser_rdata, .ser_rvalid, .ser_busy, .serial_mode,
        .predriver_blocked, .bridge_tristate, .phase_gap_time, .drain_monitor_threshold, .drain_monitor_blank,
        .sense_gain_sel, .boost_reference_sel, .fault_pwm_rate_sel, .regulator_overvolt_cutoff_en,
        .drain_fault_cutoff_en, .drain_comparator_en, .gate_uv_comparator_en, .boost_pump_en,
        .serial_port_allow, .ecc_corrected, .ecc_uncorrectable
    );
    pcs_host host (.mclk, .enable_pin, .high_side_inputs, .low_side_inputs, .fault_pull);

    // 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    // read request held one clock, answer looked at in its single valid cycle
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(negedge mclk);
        ser_addr = a;
        ser_rd = 1'b1;
        @(negedge mclk);
        ser_rd = 1'b0;
        chk({7'h0, ser_rvalid}, 8'h1);
        chk(ser_rdata, exp);
    endtask : rd

    // write request; next request only once the store is idle again
    task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic busy);
        int i;
        @(negedge mclk);
        ser_addr = a;
        ser_wdata = d;
        ser_wr = 1'b1;
        @(negedge mclk);
        ser_wr = 1'b0;
        chk({7'h0, ser_busy}, {7'h0, busy});
        for (i = 0; i < 20 && ser_busy !== 1'b0; i++) @(negedge mclk);
    endtask : wr

    task automatic try_entry(input int n, input logic [7:0] exp);
        host.pulse(n);
        repeat (6) @(negedge mclk);
        chk({7'h0, serial_mode}, exp);
    endtask : try_entry

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_defaults();
        repeat (12) @(negedge mclk);
        chk({7'h0, predriver_blocked}, 8'h0);
        chk(w2, 8'h7c);
        chk(w3, 8'ha6);
        chk(w4, 8'he0);
        chk(w5, 8'hc0);
        chk({6'h0, ecc_corrected, ecc_uncorrectable}, 8'h0);
    endtask : t_defaults

    task automatic t_cutoff(input logic en);
        chk({7'h0, bridge_tristate}, 8'h0);
        regulator_overvolt_flag = 1'b1;
        @(negedge mclk);
        chk({7'h0, bridge_tristate}, {7'h0, en});
        regulator_overvolt_flag = 1'b0;
        drain_fault_flag = 1'b1;
        @(negedge mclk);
        chk({7'h0, bridge_tristate}, {7'h0, en});
        drain_fault_flag = 1'b0;
        repeat (2) @(negedge mclk);
    endtask : t_cutoff

    task automatic t_entry();
        host.park();
        errors_pending = 1'b1;
        try_entry(30, 8'h0);
        errors_pending = 1'b0;
        try_entry(10, 8'h0);
        try_entry(60, 8'h0);
        try_entry(30, 8'h1);
    endtask : t_entry

    task automatic t_program();
        rd(3'h3, 8'ha6);
        wr(3'h0, 8'hff, 1'b0);
        rd(3'h0, 8'h00);
        wr(3'h2, 8'h00, 1'b1);
        rd(3'h2, 8'h00);
        wr(3'h3, 8'hff, 1'b1);
        rd(3'h3, 8'hee);
        wr(3'h4, 8'h00, 1'b1);
        wr(3'h5, 8'h00, 1'b1);
        wr(3'h5, 8'hff, 1'b1);
        rd(3'h5, 8'h40);
    endtask : t_program

    task automatic t_exit();
        int i;
        host.leave();
        for (i = 0; i < 10 && fault_line_oe !== 1'b1; i++) @(negedge mclk);
        chk({6'h0, fault_line_oe, predriver_blocked}, 8'h3);
        for (i = 0; i < 30 && predriver_blocked !== 1'b0; i++) @(negedge mclk);
        chk({6'h0, fault_line_oe, serial_mode}, 8'h0);
        chk(w2, 8'h00);
        chk(w3, 8'hee);
        chk(w4, 8'h00);
        chk(w5, 8'h40);
        repeat (4) @(negedge mclk);
    endtask : t_exit

    // store locked: entry still works, every write dropped
    task automatic t_locked();
        host.park();
        try_entry(30, 8'h1);
        wr(3'h2, 8'hff, 1'b0);
        host.leave();
        repeat (20) @(negedge mclk);
        chk(w2, 8'h00);
    endtask : t_locked

    // main sequence
    initial begin
        rst_n = 1'b0;
        errors_pending = 1'b0;
        regulator_overvolt_flag = 1'b0;
        drain_fault_flag = 1'b0;
        ser_wr = 1'b0;
        ser_rd = 1'b0;
        ser_addr = 3'h0;
        ser_wdata = 8'h00;
        repeat (6) @(negedge mclk);
        rst_n = 1'b1;
        t_defaults();
        t_cutoff(1'b1);
        t_entry();
        t_program();
        t_exit();
        t_cutoff(1'b0);
        t_locked();
        end_of_test();
    end

    // watchdog well beyond the few hundred clocks the run needs
    initial begin
        #100us;
        n_errors++;
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
